//--- src/btab_consts.vh
// Register map, field positions and reset values of the branch trace unit
`ifndef BTAB_CONSTS_VH
`define BTAB_CONSTS_VH

`define BTAB_ADDR_W 12
`define BTAB_OFF_SRC 12'h000
`define BTAB_OFF_DST 12'h004
`define BTAB_OFF_ASID_A 12'h008
`define BTAB_OFF_ASID_B 12'h00c
`define BTAB_OFF_CTRL 12'h010
`define BTAB_OFF_STAT 12'h014

`define BTAB_TRACE_VALID_BIT 31
`define BTAB_TRACE_RSVD_HI 30
`define BTAB_TRACE_RSVD_LO 28
`define BTAB_TRACE_ADDR_W 28
`define BTAB_ASID_W 8

`define BTAB_CTRL_TRACE_EN_BIT 0
`define BTAB_STAT_SRC_CNT_LO 0
`define BTAB_STAT_DST_CNT_LO 8
`define BTAB_STAT_SRC_LOST_BIT 16
`define BTAB_STAT_DST_LOST_BIT 17
`define BTAB_CNT_W 4

`define BTAB_QUEUE_DEPTH 8
`define BTAB_RST_ASID 8'h00
`define BTAB_RST_TRACE_EN 1'b0
`define BTAB_RST_VALID 8'h00

`endif

//--- src/btab_queue.v
// Eight-deep shift queue of trace addresses, each entry with its own valid flag
`timescale 1ns/10ps
`include "btab_consts.vh"

module btab_queue #(
  parameter DEPTH = `BTAB_QUEUE_DEPTH,
  parameter AW = `BTAB_TRACE_ADDR_W
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire push,
  input wire [AW-1:0] push_addr,
  input wire flush,
  input wire pop,
  output reg peek_valid,
  output reg [AW-1:0] peek_addr,
  output reg [`BTAB_CNT_W-1:0] fill,
  output reg lost
);

  reg [AW-1:0] addr_q [0:DEPTH-1];
  reg [DEPTH-1:0] vld_q;
  reg [DEPTH-1:0] vld_d;
  integer i;
  integer j;
  integer idx;

  // Oldest valid entry sits at the highest valid index
  function integer oldest;
    input [DEPTH-1:0] v;
    integer k;
    begin
      oldest = DEPTH - 1;
      for (k = 0; k < DEPTH; k = k + 1) begin
        if (v[k]) begin
          oldest = k;
        end
      end
    end
  endfunction

  always @* begin
    idx = oldest(vld_q);
    peek_valid = vld_q[idx];
    peek_addr = addr_q[idx];
    fill = {`BTAB_CNT_W{1'b0}};
    for (i = 0; i < DEPTH; i = i + 1) begin
      fill = fill + {{(`BTAB_CNT_W-1){1'b0}}, vld_q[i]};
    end
    vld_d = vld_q;
    if (pop) begin
      vld_d[idx] = 1'b0; // see [R03] [R08]
    end
    // An entry read or flushed in this cycle is not an overflow loss
    lost = push & vld_d[DEPTH-1] & ~flush;
    if (push) begin
      vld_d = {vld_d[DEPTH-2:0], 1'b1}; // see [R02] [R07]
    end
    if (flush) begin
      // New capture in the same cycle survives the flush
      vld_d = {{(DEPTH-1){1'b0}}, push}; // see [R03] [R08]
    end
  end

  // Valid flags alone are reset; addresses keep whatever they held
  always @(posedge clk) begin
    if (rst) begin
      vld_q <= {DEPTH{1'b0}}; // see [R03] [R08] [R04]
    end else if (ce) begin
      vld_q <= vld_d;
    end
  end

  always @(posedge clk) begin
    if (ce && push && !rst) begin
      addr_q[0] <= push_addr; // see [R05] [R09] [R04]
      for (j = 1; j < DEPTH; j = j + 1) begin
        addr_q[j] <= addr_q[j-1];
      end
    end
  end

endmodule

//--- src/btab_trace.v
// Branch trace queues and break space-id compare registers behind an APB slave
//
// The register offsets and the APB register port were decided locally.
`timescale 1ns/10ps
`include "btab_consts.vh"

// Function
// [R01] Each branch stores source address bits 27..0 in the source trace word; the code stores only branches taken while trace_enable is set.
// [R02] A captured source entry gets its valid flag, bit 31, set.
// [R03] Source valid clears on its read, on trace enable write, or reset.
// [R04] Reset clears valid flags only; stored trace addresses stay untouched.
// [R05] Source trace is an eight-entry queue shifted on every branch; the code shifts only on branches taken while trace_enable is set.
// [R06] Each branch stores destination address bits 27..0 in destination trace; the code stores only branches taken while trace_enable is set.
// [R07] A captured destination entry gets its valid flag, bit 31, set.
// [R08] Destination valid clears on read, trace enable write, or reset.
// [R09] Destination trace is an eight-entry queue shifted on every branch; the code shifts only on branches taken while trace_enable is set.
// [R10] Trace word bits 30..28 always read as zero.
// [R11] Eight-bit read/write space id compare value for channel A.
// [R12] Eight-bit read/write space id compare value for channel B.
// [R13] Trace writes are ignored; reads return values before the valid clear.
module btab_trace #(
  parameter DEPTH = `BTAB_QUEUE_DEPTH,
  parameter AW = `BTAB_TRACE_ADDR_W,
  parameter IDW = `BTAB_ASID_W
) (
  input wire clk,
  input wire rst,
  input wire ce,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [`BTAB_ADDR_W-1:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire branch_taken,
  input wire [31:0] branch_src_pc,
  input wire [31:0] branch_dst_pc,
  input wire [IDW-1:0] current_space_id,
  output reg [IDW-1:0] channel_a_space_id_bits,
  output reg [IDW-1:0] channel_b_space_id_bits,
  output reg channel_a_space_id_match,
  output reg channel_b_space_id_match,
  output reg trace_enable
);

  localparam ST_IDLE = 3'b001;
  localparam ST_WAIT = 3'b010;
  localparam ST_DONE = 3'b100;

  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [31:0] rdata_d;
  reg err_d;
  reg rd_src_pop;
  reg rd_dst_pop;
  reg wr_ctrl;
  reg wr_asid_a;
  reg wr_asid_b;
  reg wr_stat;
  reg src_lost_q;
  reg dst_lost_q;
  reg trace_flush;
  reg capture;

  wire src_peek_valid;
  wire [AW-1:0] src_peek_addr;
  wire [`BTAB_CNT_W-1:0] src_fill;
  wire src_lost;
  wire dst_peek_valid;
  wire [AW-1:0] dst_peek_addr;
  wire [`BTAB_CNT_W-1:0] dst_fill;
  wire dst_lost;

  wire access = psel & penable;
  wire latch_edge = access & (state_q == ST_IDLE);
  wire done_edge = access & (state_q == ST_DONE);

  // Same packing for both trace words so the reserved field stays zero
  function [31:0] trace_word;
    input valid;
    input [AW-1:0] addr;
    begin
      trace_word = 32'h0000_0000;
      trace_word[`BTAB_TRACE_VALID_BIT] = valid; // see [R02] [R07]
      trace_word[`BTAB_TRACE_RSVD_HI:`BTAB_TRACE_RSVD_LO] = 3'h0; // see [R10]
      trace_word[AW-1:0] = addr; // see [R01] [R06]
    end
  endfunction

  // Decode shared by read latch and write commit
  function [2:0] reg_sel;
    input [`BTAB_ADDR_W-1:0] a;
    begin
      if (a == `BTAB_OFF_SRC) begin
        reg_sel = 3'h1;
      end else if (a == `BTAB_OFF_DST) begin
        reg_sel = 3'h2;
      end else if (a == `BTAB_OFF_ASID_A) begin
        reg_sel = 3'h3;
      end else if (a == `BTAB_OFF_ASID_B) begin
        reg_sel = 3'h4;
      end else if (a == `BTAB_OFF_CTRL) begin
        reg_sel = 3'h5;
      end else if (a == `BTAB_OFF_STAT) begin
        reg_sel = 3'h6;
      end else begin
        reg_sel = 3'h0;
      end
    end
  endfunction

  // Branch events come from core logic on this clock, so no synchroniser
  always @* begin
    capture = branch_taken & trace_enable;
  end

  // APB slave sequence: latch, then ready, then one wait cycle, then back to idle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (access) begin
          state_d = ST_DONE;
        end
      end
      ST_DONE: begin
        state_d = ST_WAIT;
      end
      ST_WAIT: begin
        state_d = ST_IDLE;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // Read data and error are captured one edge before ready is seen
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d = 1'b0;
    rd_src_pop = 1'b0;
    rd_dst_pop = 1'b0;
    case (reg_sel(paddr))
      3'h1: begin
        rdata_d = trace_word(src_peek_valid, src_peek_addr); // see [R13]
        rd_src_pop = latch_edge & ~pwrite; // see [R03]
      end
      3'h2: begin
        rdata_d = trace_word(dst_peek_valid, dst_peek_addr); // see [R13]
        rd_dst_pop = latch_edge & ~pwrite; // see [R08]
      end
      3'h3: begin
        rdata_d[IDW-1:0] = channel_a_space_id_bits; // see [R11]
      end
      3'h4: begin
        rdata_d[IDW-1:0] = channel_b_space_id_bits; // see [R12]
      end
      3'h5: begin
        rdata_d[`BTAB_CTRL_TRACE_EN_BIT] = trace_enable;
      end
      3'h6: begin
        rdata_d[`BTAB_STAT_SRC_CNT_LO+`BTAB_CNT_W-1:`BTAB_STAT_SRC_CNT_LO] = src_fill;
        rdata_d[`BTAB_STAT_DST_CNT_LO+`BTAB_CNT_W-1:`BTAB_STAT_DST_CNT_LO] = dst_fill;
        rdata_d[`BTAB_STAT_SRC_LOST_BIT] = src_lost_q;
        rdata_d[`BTAB_STAT_DST_LOST_BIT] = dst_lost_q;
      end
      default: begin
        err_d = 1'b1;
      end
    endcase
  end

  // Writes commit on the edge where the master sees ready
  always @* begin
    wr_ctrl = 1'b0;
    wr_asid_a = 1'b0;
    wr_asid_b = 1'b0;
    wr_stat = 1'b0;
    if (done_edge && pwrite) begin
      if (reg_sel(paddr) == 3'h3) begin
        wr_asid_a = 1'b1;
      end else if (reg_sel(paddr) == 3'h4) begin
        wr_asid_b = 1'b1;
      end else if (reg_sel(paddr) == 3'h5) begin
        wr_ctrl = 1'b1;
      end else if (reg_sel(paddr) == 3'h6) begin
        wr_stat = 1'b1;
      end
    end
  end

  // Any write that sets the enable flushes both queues
  always @* begin
    trace_flush = wr_ctrl & pwdata[`BTAB_CTRL_TRACE_EN_BIT]; // see [R03] [R08]
  end

  always @(posedge clk) begin
    if (rst) begin
      state_q <= ST_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      state_q <= state_d;
      pready <= (state_d == ST_DONE);
      if (latch_edge) begin
        prdata <= pwrite ? 32'h0000_0000 : rdata_d;
        pslverr <= err_d;
      end else if (state_q == ST_DONE) begin
        prdata <= 32'h0000_0000;
        pslverr <= 1'b0;
      end
    end
  end

  // Trace register writes fall through the decode with no effect
  always @(posedge clk) begin
    if (rst) begin
      trace_enable <= `BTAB_RST_TRACE_EN;
      channel_a_space_id_bits <= `BTAB_RST_ASID;
      channel_b_space_id_bits <= `BTAB_RST_ASID;
    end else if (ce) begin
      if (wr_ctrl) begin
        trace_enable <= pwdata[`BTAB_CTRL_TRACE_EN_BIT];
      end
      if (wr_asid_a) begin
        channel_a_space_id_bits <= pwdata[IDW-1:0]; // see [R11]
      end
      if (wr_asid_b) begin
        channel_b_space_id_bits <= pwdata[IDW-1:0]; // see [R12]
      end
    end
  end

  // Overflow marks; a new loss in the clearing cycle wins over the clear
  always @(posedge clk) begin
    if (rst) begin
      src_lost_q <= 1'b0;
      dst_lost_q <= 1'b0;
    end else if (ce) begin
      if (src_lost) begin
        src_lost_q <= 1'b1;
      end else if (wr_stat && pwdata[`BTAB_STAT_SRC_LOST_BIT]) begin
        src_lost_q <= 1'b0;
      end
      if (dst_lost) begin
        dst_lost_q <= 1'b1;
      end else if (wr_stat && pwdata[`BTAB_STAT_DST_LOST_BIT]) begin
        dst_lost_q <= 1'b0;
      end
    end
  end

  // Registered compare keeps the break path off the space id input timing
  always @(posedge clk) begin
    if (rst) begin
      channel_a_space_id_match <= 1'b0;
      channel_b_space_id_match <= 1'b0;
    end else if (ce) begin
      channel_a_space_id_match <= (current_space_id == channel_a_space_id_bits);
      channel_b_space_id_match <= (current_space_id == channel_b_space_id_bits);
    end
  end

  btab_queue #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_src_queue (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .push(capture),
    .push_addr(branch_src_pc[AW-1:0]),
    .flush(trace_flush),
    .pop(rd_src_pop),
    .peek_valid(src_peek_valid),
    .peek_addr(src_peek_addr),
    .fill(src_fill),
    .lost(src_lost)
  );

  btab_queue #(
    .DEPTH(DEPTH),
    .AW(AW)
  ) u_dst_queue (
    .clk(clk),
    .rst(rst),
    .ce(ce),
    .push(capture),
    .push_addr(branch_dst_pc[AW-1:0]),
    .flush(trace_flush),
    .pop(rd_dst_pop),
    .peek_valid(dst_peek_valid),
    .peek_addr(dst_peek_addr),
    .fill(dst_fill),
    .lost(dst_lost)
  );

endmodule

//--- tb/btab_trace_asserts.sv
// Port checks for the branch trace unit
`timescale 1ns/10ps
module btab_trace_asserts (
  input wire clk,
  input wire rst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [7:0] current_space_id,
  input wire [7:0] channel_a_space_id_bits,
  input wire [7:0] channel_b_space_id_bits,
  input wire channel_a_space_id_match,
  input wire channel_b_space_id_match,
  input wire trace_enable
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  wire wr_done = psel && penable && pready && pwrite;
  rdy_pulse_a: assert property (pready |=> !pready) else $error("ready held");
  rd_zero_a: assert property (!(pready && !pwrite) |-> prdata == 32'h0)
    else $error("stray data");
  rsvd_zero_a: assert property (
    pready && paddr < 12'h008 |-> prdata[30:28] == 3'h0) else $error("reserved set");
  err_map_a: assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 12'h014))
    else $error("bad error flag");
  id_a_wr_a: assert property (wr_done && paddr == 12'h008 |=>
    {24'h0, channel_a_space_id_bits} == ($past(pwdata) & 32'hff))
    else $error("id a lost");
  id_b_wr_a: assert property (wr_done && paddr == 12'h00c |=>
    {24'h0, channel_b_space_id_bits} == ($past(pwdata) & 32'hff))
    else $error("id b lost");
  id_a_hold_a: assert property (!(wr_done && paddr == 12'h008) |=>
    $stable(channel_a_space_id_bits)) else $error("id a moved");
  match_late_a: assert property (!rst |=> channel_a_space_id_match ==
    ($past(current_space_id) == $past(channel_a_space_id_bits)))
    else $error("match wrong");
  match_b_late_a: assert property (!rst |=> channel_b_space_id_match ==
    ($past(current_space_id) == $past(channel_b_space_id_bits)))
    else $error("match b wrong");
  en_wr_a: assert property (wr_done && paddr == 12'h010 |=>
    {31'h0, trace_enable} == ($past(pwdata) & 32'h1)) else $error("enable lost");
  rst_vals_a: assert property ($fell(rst) |-> !trace_enable &&
    channel_b_space_id_bits == 8'h0) else $error("reset values");
endmodule

//--- tb/btab_core_model.sv
// Behavioural core issuing branch events
`timescale 1ns/10ps
module btab_core_model (
  input wire clk,
  input wire go,
  input wire [31:0] addr,
  output reg branch_taken = 1'h0,
  output reg [31:0] src_pc = 32'h0,
  output reg [31:0] dst_pc = 32'h0
);
  // Addresses toggle between branches so stale values never look valid
  always @(posedge clk) begin
    branch_taken <= go;
    src_pc <= go ? addr : ~src_pc;
    dst_pc <= go ? {addr[15:0], addr[31:16]} : ~dst_pc;
  end
endmodule

//--- tb/btab_trace_tb.sv
// Self-checking bench for the branch trace unit
`timescale 1ns/10ps
module btab_trace_tb;
  reg clk = 1'h0, rst = 1'h1, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, go = 1'h0, e;
  reg [11:0] paddr = 12'h0;
  reg [31:0] pwdata = 32'h0, bra = 32'h0, r;
  reg [7:0] cur_id = 8'h0;
  wire [31:0] prdata, spc, dpc;
  wire pready, pslverr, bt, ma, mb, ten;
  wire [7:0] ida, idb;
  int num_errors = 0, compares = 0, i;
  always #4 clk = ~clk;
  btab_core_model i_core (.clk(clk), .go(go), .addr(bra), .branch_taken(bt),
    .src_pc(spc), .dst_pc(dpc));
  btab_trace i_dut (.clk(clk), .rst(rst), .ce(1'h1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .branch_taken(bt), .branch_src_pc(spc), .branch_dst_pc(dpc),
    .current_space_id(cur_id), .channel_a_space_id_bits(ida), .channel_b_space_id_bits(idb),
    .channel_a_space_id_match(ma), .channel_b_space_id_match(mb), .trace_enable(ten));
  function [31:0] sv(input int k); sv = 32'hf1234560 + k * 32'h101; endfunction
  function [31:0] sw(input [31:0] s); sw = {4'h8, s[27:0]}; endfunction
  function [31:0] dw(input [31:0] s); dw = {4'h8, s[11:0], s[31:16]}; endfunction
  task chk(input [31:0] got, input [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Holds the request until pready is seen; only the watchdog ends a dead wait
  task apb(input w, input [11:0] a, input [31:0] d);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do begin
      @(posedge clk);
    end while (pready !== 1'h1);
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge clk);
  endtask
  task rd(input [11:0] a, input [31:0] exp);
    apb(1'h0, a, 32'h0);
    chk(r, exp);
  endtask
  task rdz(input [11:0] a);
    apb(1'h0, a, 32'h0);
    chk(r & 32'hf0000000, 32'h0);
  endtask
  task br(input [31:0] s);
    @(posedge clk);
    bra <= s;
    go <= 1'h1;
    @(posedge clk);
    go <= 1'h0;
  endtask
  task print_verdict;
    if (num_errors == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    rdz(12'h000);
    rd(12'h008, 32'h0);
    br(sv(12));
    rdz(12'h000);
    apb(1'h1, 12'h010, 32'h1);
    rd(12'h010, 32'h1);
    chk({31'h0, ten}, 32'h1);
    for (i = 0; i < 3; i++) br(sv(i));
    apb(1'h1, 12'h000, 32'h0);
    apb(1'h1, 12'h004, 32'h0);
    for (i = 0; i < 3; i++) rd(12'h000, sw(sv(i)));
    for (i = 0; i < 3; i++) rd(12'h004, dw(sv(i)));
    rdz(12'h000);
    rdz(12'h004);
    for (i = 0; i < 9; i++) br(sv(i));
    rd(12'h014, 32'h00030808);
    for (i = 1; i < 9; i++) rd(12'h000, sw(sv(i)));
    apb(1'h1, 12'h014, 32'h00010000);
    rd(12'h014, 32'h00020800);
    apb(1'h1, 12'h010, 32'h1);
    rd(12'h004, dw(sv(1)) & 32'h0fffffff);
    br(sv(9));
    br(sv(10));
    @(posedge clk);
    rst <= 1'h1;
    repeat (3) @(posedge clk);
    rst <= 1'h0;
    @(posedge clk);
    chk({31'h0, ten}, 32'h0);
    rd(12'h014, 32'h0);
    rd(12'h000, sw(sv(3)) & 32'h0fffffff);
    apb(1'h1, 12'h008, 32'hffffffa5);
    apb(1'h1, 12'h00c, 32'h0000005a);
    rd(12'h008, 32'ha5);
    rd(12'h00c, 32'h5a);
    cur_id <= 8'ha5;
    repeat (3) @(posedge clk);
    chk({ma, mb, ida, idb}, {2'h2, 16'ha55a});
    cur_id <= 8'h5a;
    repeat (3) @(posedge clk);
    chk({ma, mb}, 2'h1);
    rd(12'h018, 32'h0);
    chk({31'h0, e}, 32'h1);
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge clk);
    num_errors++;
    print_verdict;
  end
endmodule
bind btab_trace btab_trace_asserts i_chk (.clk(clk), .rst(rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .current_space_id(current_space_id),
  .channel_a_space_id_bits(channel_a_space_id_bits),
  .channel_b_space_id_bits(channel_b_space_id_bits),
  .channel_a_space_id_match(channel_a_space_id_match),
  .channel_b_space_id_match(channel_b_space_id_match), .trace_enable(trace_enable));
